// >>> core/hel_pkg.sv
// shared constants and carrier types for the error log register bank
package hel_pkg;

	////////////////////////////////////////////////////////////////////////
	// bus geometry
	localparam int AXI_ADDR_W = 12; // byte address width of the register bus
	localparam int IDX_W = AXI_ADDR_W - 2; // word index width

	////////////////////////////////////////////////////////////////////////
	// register indexes, byte address is four times the index
	localparam logic [IDX_W-1:0] IDX_CMD = 10'h004; // function_command_word
	localparam logic [IDX_W-1:0] IDX_LATENCY = 10'h00d; // bus_master_latency
	localparam logic [IDX_W-1:0] IDX_HDR = 10'h00e; // header_layout_code
	localparam logic [IDX_W-1:0] IDX_VENDOR = 10'h02c; // board_vendor_code
	localparam logic [IDX_W-1:0] IDX_PRODUCT = 10'h02e; // board_product_code
	localparam logic [IDX_W-1:0] IDX_G_FIRST = 10'h040; // global_first_fault_log
	localparam logic [IDX_W-1:0] IDX_G_LATER = 10'h044; // global_later_fault_log
	localparam logic [IDX_W-1:0] IDX_G_SYSEN = 10'h048; // global_syserr_enables
	localparam logic [IDX_W-1:0] IDX_L_FIRST = 10'h050; // link_first_fault_log
	localparam logic [IDX_W-1:0] IDX_L_LATER = 10'h052; // link_later_fault_log
	localparam logic [IDX_W-1:0] IDX_L_SCI = 10'h058; // link_sci_enables
	localparam logic [IDX_W-1:0] IDX_L_SMI = 10'h05a; // link_smi_enables
	localparam logic [IDX_W-1:0] IDX_L_SYS = 10'h05c; // link_syserr_enables
	localparam logic [IDX_W-1:0] IDX_HIDE = 10'h070; // function_hide_control

	////////////////////////////////////////////////////////////////////////
	// field positions and masks
	localparam int CMD_SYSERR_BIT = 8; // global_syserr_enable
	localparam int G_MEM_BIT = 18;
	localparam int G_LEGACY_BIT = 17;
	localparam int G_SYSBUS_BIT = 16;
	localparam int G_LINK4_BIT = 4;
	localparam int G_LINK3_BIT = 3;
	localparam int G_LINK2_BIT = 2;
	localparam int L_TABORT_BIT = 6;
	localparam int L_DPAR_BIT = 4;
	localparam int L_APAR_BIT = 0;
	localparam int HIDE_BIT = 0;
	localparam logic [31:0] G_VALID = 32'h0007_001c; // implemented global bits
	localparam logic [31:0] G_GROUP = 32'h0007_0000; // bits 18:16 block together
	localparam logic [7:0] L_VALID = 8'h51; // implemented link bits
	localparam logic [15:0] CMD_VALID = 16'h0100;

	////////////////////////////////////////////////////////////////////////
	// reset and fixed values
	localparam logic [15:0] CODE_RESET = 16'h0000;
	localparam logic [31:0] G_RESET = 32'h0000_0000;
	localparam logic [7:0] L_RESET = 8'h00;
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic HIDE_RESET = 1'b0;
	localparam logic [7:0] HDR_MULTI = 8'h80; // second function visible
	localparam logic [7:0] HDR_SINGLE = 8'h00; // second function hidden
	localparam logic [7:0] LATENCY_VALUE = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic [AXI_ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [AXI_ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} hel_axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} hel_axil_rsp_s;

	typedef struct packed {
		logic memIfErr; // memory interface error
		logic legacyLinkErr; // legacy_hub_link error
		logic sysBusErr; // system bus error
		logic link4Err; // expansion_link_four error
		logic link3Err; // expansion_link_three error
		logic link2Err; // expansion_link_two error
		logic linkTargetAbort; // own cycle ended by target abort
		logic linkDataParity; // link data parity error
		logic linkAddrParity; // link address or command parity error
	} hel_fault_in_s;

endpackage

// >>> core/hel_axil_port.sv
// axi4-lite slave front end for the error log register bank
`timescale 1ns/1ns
module hel_axil_port (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire hel_pkg::hel_axil_req_s axiReq,
	output hel_pkg::hel_axil_rsp_s axiRsp,
	output logic wrEn,
	output logic [hel_pkg::AXI_ADDR_W-1:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrHit,
	output logic [hel_pkg::AXI_ADDR_W-1:0] rdAddr,
	input wire logic [31:0] rdData,
	input wire logic rdHit
);
	import hel_pkg::*;

	logic awHeld; // write address captured
	logic wHeld; // write data captured
	logic rdPend; // read address captured, data next edge
	logic awReady; // write address channel open
	logic wReady; // write data channel open
	logic bValid; // write answer standing
	logic [1:0] bResp; // write answer code
	logic arReady; // read address channel open
	logic rValid; // read answer standing
	logic [31:0] rWord; // read answer data
	logic [1:0] rResp; // read answer code
	wire awTake = axiReq.awvalid & awReady; // address handshake
	wire wTake = axiReq.wvalid & wReady; // data handshake
	wire bTake = bValid & axiReq.bready; // response handshake
	wire arTake = axiReq.arvalid & arReady;
	wire rTake = rValid & axiReq.rready;

	// answer fields come from two processes, gathered here in struct order
	assign axiRsp = {awReady, wReady, bValid, bResp, arReady, rValid, rWord, rResp};

	// register update fires once both halves are held
	assign wrEn = awHeld & wHeld & ~bValid;

	////////////////////////////////////////////////////////////////////////
	// write channels, address and data accepted in either order
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wrAddr <= '0;
			wrData <= 32'h0000_0000;
			wrStrb <= 4'h0;
			awReady <= 1'b1;
			wReady <= 1'b1;
			bValid <= 1'b0;
			bResp <= RESP_OKAY;
		end else begin
			if (awTake) begin
				// hold address, stop taking more
				wrAddr <= axiReq.awaddr;
				awHeld <= 1'b1;
				awReady <= 1'b0;
			end
			if (wTake) begin
				// hold data and lanes
				wrData <= axiReq.wdata;
				wrStrb <= axiReq.wstrb;
				wHeld <= 1'b1;
				wReady <= 1'b0;
			end
			if (wrEn) begin
				// answer, unmapped address gets decode error
				bValid <= 1'b1;
				bResp <= wrHit ? RESP_OKAY : RESP_DECERR;
				awHeld <= 1'b0;
				wHeld <= 1'b0;
			end
			if (bTake) begin
				// reopen both channels
				bValid <= 1'b0;
				awReady <= 1'b1;
				wReady <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read channels, data registered one edge after the address
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdPend <= 1'b0;
			rdAddr <= '0;
			arReady <= 1'b1;
			rValid <= 1'b0;
			rWord <= 32'h0000_0000;
			rResp <= RESP_OKAY;
		end else begin
			if (arTake) begin
				rdAddr <= axiReq.araddr;
				rdPend <= 1'b1;
				arReady <= 1'b0;
			end
			if (rdPend) begin
				// unmapped reads return zero with decode error
				rdPend <= 1'b0;
				rValid <= 1'b1;
				rWord <= rdData;
				rResp <= rdHit ? RESP_OKAY : RESP_DECERR;
			end
			if (rTake) begin
				rValid <= 1'b0;
				arReady <= 1'b1;
			end
		end
	end

endmodule

// >>> core/hel_error_bank.sv
// error log register bank with first and later fault logs and message enables
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module hel_error_bank (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire hel_pkg::hel_axil_req_s axiReq,
	output hel_pkg::hel_axil_rsp_s axiRsp,
	input wire hel_pkg::hel_fault_in_s faultIn,
	output logic sysErrPulse,
	output logic smiLevel,
	output logic sciLevel
);
	import hel_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// bus front end wires
	logic wrEn; // one-cycle register write
	logic [AXI_ADDR_W-1:0] wrAddr; // held write address
	logic [31:0] wrData; // held write data
	logic [3:0] wrStrb; // held byte lanes
	logic [AXI_ADDR_W-1:0] rdAddr; // held read address
	logic [31:0] rdData; // read value for held address
	logic rdHit; // read address is mapped
	logic wrHit; // write address is mapped

	hel_axil_port port (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.axiReq(axiReq),
		.axiRsp(axiRsp),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrHit(wrHit),
		.rdAddr(rdAddr),
		.rdData(rdData),
		.rdHit(rdHit)
	);

	////////////////////////////////////////////////////////////////////////
	// register state
	logic [15:0] cmdWord; // function_command_word
	logic [15:0] vendorCode; // board_vendor_code
	logic vendorLocked; // vendor code already written
	logic [15:0] productCode; // board_product_code
	logic productLocked; // product code already written
	logic hideFunc; // function_hide_control
	logic [31:0] gFirst; // global_first_fault_log
	logic [31:0] gLater; // global_later_fault_log
	logic [31:0] gSysEn; // global_syserr_enables
	logic [7:0] lFirst; // link_first_fault_log
	logic [7:0] lLater; // link_later_fault_log
	logic [7:0] lSciEn; // link_sci_enables
	logic [7:0] lSmiEn; // link_smi_enables
	logic [7:0] lSysEn; // link_syserr_enables

	////////////////////////////////////////////////////////////////////////
	// write address decode
	wire [IDX_W-1:0] wrIdx = wrAddr[AXI_ADDR_W-1:2]; // word index
	// identity and control words
	wire wsCmd = wrIdx == IDX_CMD;
	wire wsLatency = wrIdx == IDX_LATENCY;
	wire wsHdr = wrIdx == IDX_HDR;
	wire wsVendor = wrIdx == IDX_VENDOR;
	wire wsProduct = wrIdx == IDX_PRODUCT;

	// fault logs, message enables and hide control
	wire wsGFirst = wrIdx == IDX_G_FIRST;
	wire wsGLater = wrIdx == IDX_G_LATER;
	wire wsGSysEn = wrIdx == IDX_G_SYSEN;
	wire wsLFirst = wrIdx == IDX_L_FIRST;
	wire wsLLater = wrIdx == IDX_L_LATER;
	wire wsLSci = wrIdx == IDX_L_SCI;
	wire wsLSmi = wrIdx == IDX_L_SMI;
	wire wsLSys = wrIdx == IDX_L_SYS;
	wire wsHide = wrIdx == IDX_HIDE;

	// read-only words take the write but change nothing
	assign wrHit = wsCmd
		| wsLatency
		| wsHdr
		| wsVendor
		| wsProduct
		| wsGFirst
		| wsGLater
		| wsGSysEn
		| wsLFirst
		| wsLLater
		| wsLSci
		| wsLSmi
		| wsLSys
		| wsHide;

	////////////////////////////////////////////////////////////////////////
	// byte lane mask from the write strobes
	logic [31:0] laneMask; // one byte of ones per written lane
	genvar lane;
	generate
		for (lane = 0; lane < 4; lane++) begin : gLane
			assign laneMask[8*lane +: 8] = {8{wrStrb[lane]}};
		end
	endgenerate

	wire [31:0] wrBits = wrData & laneMask; // written ones within lanes
	// any write touching the low lanes locks the code, even a single byte
	wire vendorWrite = wrEn & wsVendor & (|wrStrb[1:0]) & ~vendorLocked;
	wire productWrite = wrEn & wsProduct & (|wrStrb[1:0]) & ~productLocked;

	// merge of old value and written lanes
	function automatic logic [31:0] hel_merge(input logic [31:0] oldVal, input logic [31:0] newVal,
		input logic [31:0] mask);
		hel_merge = (oldVal & ~mask) | (newVal & mask);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// fault events mapped onto log bit positions
	wire [31:0] gEv = (32'(faultIn.memIfErr) << G_MEM_BIT)
		| (32'(faultIn.legacyLinkErr) << G_LEGACY_BIT)
		| (32'(faultIn.sysBusErr) << G_SYSBUS_BIT)
		| (32'(faultIn.link4Err) << G_LINK4_BIT)
		| (32'(faultIn.link3Err) << G_LINK3_BIT)
		| (32'(faultIn.link2Err) << G_LINK2_BIT);
	wire [7:0] lEv = (8'(faultIn.linkTargetAbort) << L_TABORT_BIT)
		| (8'(faultIn.linkDataParity) << L_DPAR_BIT)
		| (8'(faultIn.linkAddrParity) << L_APAR_BIT);

	////////////////////////////////////////////////////////////////////////
	// global logs, capture and blocking
	wire [31:0] gClrF = (wrEn & wsGFirst) ? wrBits : 32'h0000_0000;
	wire [31:0] gClrL = (wrEn & wsGLater) ? wrBits : 32'h0000_0000;
	wire [31:0] gFirstKept = gFirst & ~gClrF; // first log after software clear
	wire gFirstEmpty = gFirstKept == 32'h0000_0000; // room for a new first error
	// two events in one cycle: lowest bit enters, the rest go to the later log except those grouped with it
	wire [31:0] gLowest = gEv & (~gEv + 32'h0000_0001); // lowest event wins a tie
	wire [31:0] gCapture = gFirstEmpty ? gLowest : 32'h0000_0000;
	wire [31:0] next_gFirst = (gFirstKept | gCapture) & G_VALID;
	// memory, legacy link and system bus count as one source for blocking
	wire gGroupHeld = |(next_gFirst & G_GROUP); // a grouped bit sits in first log
	wire [31:0] gBlock = next_gFirst | (gGroupHeld ? G_GROUP : 32'h0000_0000);
	wire [31:0] gLaterSet = gEv & ~gCapture & ~gBlock;
	// an event in the cycle of its own clear keeps the bit set
	wire [31:0] next_gLater = ((gLater & ~gClrL) | gLaterSet) & G_VALID; // set wins over clear
	wire [31:0] gRise = (next_gFirst & ~gFirst) | (next_gLater & ~gLater);

	////////////////////////////////////////////////////////////////////////
	// link logs, one bit in first, rest to later
	wire [7:0] lClrF = (wrEn & wsLFirst) ? wrBits[7:0] : 8'h00;
	wire [7:0] lClrL = (wrEn & wsLLater) ? wrBits[7:0] : 8'h00;
	wire [7:0] lFirstKept = lFirst & ~lClrF;
	wire lFirstEmpty = lFirstKept == 8'h00;
	// link first log must never hold two bits
	wire [7:0] lLowest = lEv & (~lEv + 8'h01); // only one bit may enter
	wire [7:0] lCapture = lFirstEmpty ? lLowest : 8'h00;
	wire [7:0] next_lFirst = (lFirstKept | lCapture) & L_VALID;
	wire [7:0] lLaterSet = lEv & ~lCapture;
	wire [7:0] next_lLater = ((lLater & ~lClrL) | lLaterSet) & L_VALID;
	wire [7:0] lRise = (next_lFirst & ~lFirst) | (next_lLater & ~lLater);
	wire [7:0] lAny = lFirst | lLater; // bit set in either link log

	////////////////////////////////////////////////////////////////////////
	// message generation
	wire serrOn = cmdWord[CMD_SYSERR_BIT];
	wire gSysHit = |(gRise & gSysEn);
	wire lSysHit = |(lRise & lSysEn);
	// one pulse in a cycle where any enabled flag rises, so a flag left set does not repeat the message
	wire next_sysErr = serrOn & (gSysHit | lSysHit);
	// smi and sci follow the link logs as levels until software clears them
	wire next_smi = |(lAny & lSmiEn);
	wire next_sci = |(lAny & lSciEn);

	////////////////////////////////////////////////////////////////////////
	// global fault logs, updated every edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			gFirst <= G_RESET;
			gLater <= G_RESET;
		end else begin
			gFirst <= next_gFirst;
			gLater <= next_gLater;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link fault logs, updated every edge
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			lFirst <= L_RESET;
			lLater <= L_RESET;
		end else begin
			lFirst <= next_lFirst;
			lLater <= next_lLater;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write-once vendor code
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			vendorCode <= CODE_RESET;
			vendorLocked <= 1'b0;
		end else if (vendorWrite) begin
			// first write lands, then read-only until reset
			vendorCode <= 16'(hel_merge({16'h0000, vendorCode}, wrData, laneMask));
			vendorLocked <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write-once product code
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			productCode <= CODE_RESET;
			productLocked <= 1'b0;
		end else if (productWrite) begin
			// firmware sets it once at start-up
			productCode <= 16'(hel_merge({16'h0000, productCode}, wrData, laneMask));
			productLocked <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// plain read-write control registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cmdWord <= CMD_RESET;
			gSysEn <= G_RESET;
			lSciEn <= L_RESET;
			lSmiEn <= L_RESET;
			lSysEn <= L_RESET;
			hideFunc <= HIDE_RESET;
		end else if (wrEn) begin
			// reserved bits masked off on every store
			if (wsCmd) begin
				cmdWord <= 16'(hel_merge({16'h0000, cmdWord}, wrData, laneMask)) & CMD_VALID;
			end
			if (wsGSysEn) begin
				gSysEn <= hel_merge(gSysEn, wrData, laneMask) & G_VALID;
			end
			if (wsLSci) begin
				lSciEn <= 8'(hel_merge({24'h000000, lSciEn}, wrData, laneMask)) & L_VALID;
			end
			if (wsLSmi) begin
				lSmiEn <= 8'(hel_merge({24'h000000, lSmiEn}, wrData, laneMask)) & L_VALID;
			end
			if (wsLSys) begin
				lSysEn <= 8'(hel_merge({24'h000000, lSysEn}, wrData, laneMask)) & L_VALID;
			end
			if (wsHide & wrStrb[0]) begin
				hideFunc <= wrData[HIDE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// message outputs, registered
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sysErrPulse <= 1'b0;
			smiLevel <= 1'b0;
			sciLevel <= 1'b0;
		end else begin
			sysErrPulse <= next_sysErr;
			smiLevel <= next_smi;
			sciLevel <= next_sci;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read address decode and data selection
	wire [IDX_W-1:0] rdIdx = rdAddr[AXI_ADDR_W-1:2];
	// identity and control words
	wire rsCmd = rdIdx == IDX_CMD;
	wire rsLatency = rdIdx == IDX_LATENCY;
	wire rsHdr = rdIdx == IDX_HDR;
	wire rsVendor = rdIdx == IDX_VENDOR;
	wire rsProduct = rdIdx == IDX_PRODUCT;

	// fault logs, message enables and hide control
	wire rsGFirst = rdIdx == IDX_G_FIRST;
	wire rsGLater = rdIdx == IDX_G_LATER;
	wire rsGSysEn = rdIdx == IDX_G_SYSEN;
	wire rsLFirst = rdIdx == IDX_L_FIRST;
	wire rsLLater = rdIdx == IDX_L_LATER;
	wire rsLSci = rdIdx == IDX_L_SCI;
	wire rsLSmi = rdIdx == IDX_L_SMI;
	wire rsLSys = rdIdx == IDX_L_SYS;
	wire rsHide = rdIdx == IDX_HIDE;
	// header code follows the hide control, no storage of its own
	wire [7:0] hdrValue = hideFunc ? HDR_SINGLE : HDR_MULTI;

	assign rdHit = rsCmd
		| rsLatency
		| rsHdr
		| rsVendor
		| rsProduct
		| rsGFirst
		| rsGLater
		| rsGSysEn
		| rsLFirst
		| rsLLater
		| rsLSci
		| rsLSmi
		| rsLSys
		| rsHide;

	// narrow words hold the value in the low bits with upper bits zero, the global words are read whole with only the G_VALID bits ever set
	assign rdData = ({32{rsCmd}} & {16'h0000, cmdWord})
		| ({32{rsLatency}} & {24'h000000, LATENCY_VALUE})
		| ({32{rsHdr}} & {24'h000000, hdrValue})
		| ({32{rsVendor}} & {16'h0000, vendorCode})
		| ({32{rsProduct}} & {16'h0000, productCode})
		| ({32{rsGFirst}} & gFirst)
		| ({32{rsGLater}} & gLater)
		| ({32{rsGSysEn}} & gSysEn)
		| ({32{rsLFirst}} & {24'h000000, lFirst})
		| ({32{rsLLater}} & {24'h000000, lLater})
		| ({32{rsLSci}} & {24'h000000, lSciEn})
		| ({32{rsLSmi}} & {24'h000000, lSmiEn})
		| ({32{rsLSys}} & {24'h000000, lSysEn})
		| ({32{rsHide}} & {31'h00000000, hideFunc});

endmodule

// >>> sim/hel_error_bank_asserts.sv
// port checker for the error log register bank
`timescale 1ns/1ns
module hel_error_bank_asserts (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire hel_pkg::hel_axil_req_s axiReq,
	input wire hel_pkg::hel_axil_rsp_s axiRsp,
	input wire hel_pkg::hel_fault_in_s faultIn,
	input wire logic sysErrPulse,
	input wire logic smiLevel,
	input wire logic sciLevel
);
	import hel_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////////
	// bus answers come in a bounded time and block a second request
	a_read_answer: assert property (axiReq.arvalid && axiRsp.arready |-> ##[1:3] axiRsp.rvalid)
		else $error("read answer missing");
	a_write_answer: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
		|-> ##[1:3] axiRsp.bvalid) else $error("write answer missing");
	a_ar_refused: assert property (axiReq.arvalid && axiRsp.arready |=> !axiRsp.arready)
		else $error("read address taken twice");
	a_aw_refused: assert property (axiReq.awvalid && axiRsp.awready |=> !axiRsp.awready)
		else $error("write address taken twice");
	a_decerr_zero: assert property (axiRsp.rvalid && axiRsp.rresp == RESP_DECERR |-> axiRsp.rdata == 32'h0)
		else $error("unmapped read returned data");
	////////////////////////////////////////////////////////////////////////
	// messages need a cause: an event for the pulse, a write for a falling level
	a_pulse_cause: assert property (sysErrPulse |-> $past(faultIn) != '0)
		else $error("system error pulse without event");
	a_smi_falls: assert property ($fell(smiLevel) |-> $past(axiRsp.bvalid) || $past(axiRsp.bvalid, 2))
		else $error("smi level dropped without write");
	a_sci_falls: assert property ($fell(sciLevel) |-> $past(axiRsp.bvalid) || $past(axiRsp.bvalid, 2))
		else $error("sci level dropped without write");
endmodule
bind hel_error_bank hel_error_bank_asserts i_chk (.clk_sys(clk_sys), .nrst(nrst), .axiReq(axiReq),
	.axiRsp(axiRsp), .faultIn(faultIn), .sysErrPulse(sysErrPulse), .smiLevel(smiLevel), .sciLevel(sciLevel));

// >>> sim/hel_fault_src.sv
// event source standing in for the internal error detectors
`timescale 1ns/1ns
module hel_fault_src (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic fire,
	input wire logic [8:0] pattern,
	output hel_pkg::hel_fault_in_s faultIn
);
	import hel_pkg::*;
	// one-cycle event pulse per strobe, quiet between events
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			faultIn <= '0;
		end else begin
			faultIn <= fire ? hel_fault_in_s'(pattern) : '0;
		end
	end
endmodule

// >>> sim/hel_error_bank_tb.sv
// self-checking bench for the error log register bank
`timescale 1ns/1ns
module hel_error_bank_tb;
	import hel_pkg::*;
	localparam logic [IDX_W-1:0] R_IDX [12] = '{IDX_HDR, IDX_LATENCY, IDX_VENDOR, IDX_PRODUCT, IDX_G_FIRST,
		IDX_G_LATER, IDX_L_FIRST, IDX_L_LATER, IDX_L_SCI, IDX_L_SMI, IDX_L_SYS, IDX_CMD};
	localparam logic [8:0] HAND [7] = '{9'h100, 9'h0a0, 9'h100, 9'h008, 9'h1ff, 9'h002, 9'h010};
	logic clk_sys;
	logic nrst;
	hel_axil_req_s req; // master side of the bus
	hel_axil_rsp_s rsp; // slave answers
	hel_fault_in_s faultIn; // events from the source model
	logic sysErrPulse;
	logic smiLevel;
	logic sciLevel;
	logic fire; // source strobe
	logic [8:0] pattern; // source event set
	logic [31:0] gf = 0, gl = 0, gEn = 0, v1; // expected global logs
	logic [7:0] lf = 0, ll = 0, sciEn = 0, smiEn = 0, sysEn = 0; // expected link logs
	logic cmdOn = 1'b0; // expected global enable
	int error_cnt = 0;
	int n_checks = 0;
	int pulseCnt = 0;
	int expPulse = 0;
	hel_error_bank i_dut (.clk_sys(clk_sys), .nrst(nrst), .axiReq(req), .axiRsp(rsp), .faultIn(faultIn),
		.sysErrPulse(sysErrPulse), .smiLevel(smiLevel), .sciLevel(sciLevel));
	hel_fault_src i_src (.clk_sys(clk_sys), .nrst(nrst), .fire(fire), .pattern(pattern), .faultIn(faultIn));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// count pulses in the cycle they stand
	always @(posedge clk_sys) begin
		if (sysErrPulse === 1'b1) pulseCnt++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// write with both channels offered together, each released when taken
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		@(posedge clk_sys);
		req.awaddr <= {idx, 2'b00};
		req.wdata <= d;
		req.wstrb <= s;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
			if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		check(32'(rsp.bresp), 32'(er));
		req.bready <= 1'b0;
	endtask
	// read and compare data and response
	task automatic rd(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic [1:0] er);
		@(posedge clk_sys);
		req.araddr <= {idx, 2'b00};
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (rsp.arready === 1'b1) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		check(rsp.rdata, exp);
		check(32'(rsp.rresp), 32'(er));
		req.rready <= 1'b0;
	endtask
	// compare all logs and message outputs with the model
	task automatic sweep();
		rd(IDX_G_FIRST, gf, RESP_OKAY);
		rd(IDX_G_LATER, gl, RESP_OKAY);
		rd(IDX_L_FIRST, {24'h0, lf}, RESP_OKAY);
		rd(IDX_L_LATER, {24'h0, ll}, RESP_OKAY);
		check(32'(sciLevel), 32'(((lf | ll) & sciEn) != 0));
		check(32'(smiLevel), 32'(((lf | ll) & smiEn) != 0));
		check(32'(pulseCnt), 32'(expPulse));
	endtask
	// fire one event set and follow it in the model
	task automatic hit(input logic [8:0] p);
		logic [31:0] ev, cap, nl, rg;
		logic [7:0] lev, lcap, rl;
		ev = {13'h0, p[8:6], 11'h0, p[5:3], 2'h0};
		lev = {1'b0, p[2], 1'b0, p[1], 3'h0, p[0]};
		cap = (gf == 0) ? (ev & (~ev + 1)) : 32'h0;
		nl = ev & ~(gf | cap) & ((((gf | cap) & G_GROUP) != 0) ? ~G_GROUP : 32'hffff_ffff);
		rg = cap | (nl & ~gl);
		lcap = (lf == 0) ? (lev & (~lev + 1)) : 8'h0;
		rl = lcap | (lev & ~lcap & ~ll);
		gf = gf | cap;
		gl = gl | nl;
		lf = lf | lcap;
		ll = ll | (lev & ~lcap);
		if (cmdOn && (((rg & gEn) != 0) || ((rl & sysEn) != 0))) expPulse++;
		@(posedge clk_sys);
		fire <= 1'b1;
		pattern <= p;
		@(posedge clk_sys);
		fire <= 1'b0;
		repeat (4) @(posedge clk_sys);
		sweep();
	endtask
	// clear by written ones; zeros must leave bits alone
	task automatic clr(input logic [31:0] m1, input logic [31:0] m2, input logic [7:0] m3, input logic [7:0] m4);
		wr(IDX_G_FIRST, m1, 4'hf, RESP_OKAY);
		wr(IDX_G_LATER, m2, 4'hf, RESP_OKAY);
		wr(IDX_L_FIRST, {24'hff_ffff, m3}, 4'hf, RESP_OKAY);
		wr(IDX_L_LATER, {24'h0, m4}, 4'hf, RESP_OKAY);
		gf = gf & ~m1;
		gl = gl & ~m2;
		lf = lf & ~m3;
		ll = ll & ~m4;
		sweep();
	endtask
	// random enables, one message type per flag, reserved bits written high on the sci, global syserr and command words
	task automatic setup(input logic c);
		sciEn = 8'($urandom) & L_VALID;
		smiEn = 8'($urandom) & L_VALID & ~sciEn;
		sysEn = L_VALID & ~sciEn & ~smiEn;
		gEn = $urandom & G_VALID;
		cmdOn = c;
		wr(IDX_L_SCI, {24'hff_ffff, sciEn | ~L_VALID}, 4'hf, RESP_OKAY);
		wr(IDX_L_SMI, {24'h0, smiEn}, 4'hf, RESP_OKAY);
		wr(IDX_L_SYS, {24'h0, sysEn}, 4'hf, RESP_OKAY);
		wr(IDX_G_SYSEN, gEn | ~G_VALID, 4'hf, RESP_OKAY);
		wr(IDX_CMD, {23'h7f_ffff, c, 8'hff}, 4'hf, RESP_OKAY);
		rd(IDX_L_SCI, {24'h0, sciEn}, RESP_OKAY);
		rd(IDX_G_SYSEN, gEn, RESP_OKAY);
		rd(IDX_CMD, {23'h0, c, 8'h0}, RESP_OKAY);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		nrst = 1'b0;
		req = '0;
		fire = 1'b0;
		pattern = '0;
		void'($urandom(39));
		repeat (12) @(posedge clk_sys);
		nrst <= 1'b1;
		foreach (R_IDX[i]) rd(R_IDX[i], (i == 0) ? 32'(HDR_MULTI) : 32'h0, RESP_OKAY);
		wr(IDX_HDR, 32'hffff_ffff, 4'hf, RESP_OKAY);
		wr(IDX_LATENCY, 32'hffff_ffff, 4'hf, RESP_OKAY);
		rd(IDX_LATENCY, 32'(LATENCY_VALUE), RESP_OKAY);
		for (int h = 1; h >= 0; h--) begin
			wr(IDX_HIDE, 32'(h), 4'hf, RESP_OKAY);
			rd(IDX_HDR, h ? 32'(HDR_SINGLE) : 32'(HDR_MULTI), RESP_OKAY);
		end
		wr(10'h3ff, 32'hffff_ffff, 4'hf, RESP_DECERR);
		rd(10'h3ff, 32'h0, RESP_DECERR);
		for (int k = 0; k < 2; k++) begin
			v1 = $urandom;
			// vendor gets a single low lane first, which must still lock it
			wr(k ? IDX_PRODUCT : IDX_VENDOR, v1, k ? 4'hf : 4'h1, RESP_OKAY);
			wr(k ? IDX_PRODUCT : IDX_VENDOR, ~v1, 4'hf, RESP_OKAY);
			rd(k ? IDX_PRODUCT : IDX_VENDOR, {16'h0, v1[15:8] & {8{k[0]}}, v1[7:0]}, RESP_OKAY);
		end
		setup(1'b1);
		foreach (HAND[j]) begin
			if (j == 4) clr('1, '1, '1, '1);
			hit(HAND[j]);
		end
		// event in the cycle of its own clear: later bit 4 must stay, no new pulse
		fork
			wr(IDX_G_LATER, 32'h0000_0010, 4'hf, RESP_OKAY);
			begin
				@(posedge clk_sys);
				fire <= 1'b1;
				pattern <= 9'h020;
				@(posedge clk_sys);
				fire <= 1'b0;
			end
		join
		sweep();
		for (int r = 0; r < 8; r++) begin
			setup(r[0]);
			repeat (3) hit(9'($urandom));
			clr($urandom, $urandom, 8'($urandom), 8'($urandom));
		end
		results();
	end
	// hang guard, well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		results();
	end
endmodule
